// ==== rtl/timer8_waveform_control.sv ====
`timescale 1ns/1ps
`default_nettype none

module timer8_waveform_control
    import timer8_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic timer_tick,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic chan_a_pin_dir,
    input wire logic chan_b_pin_dir,
    output logic chan_a_compare_pin,
    output logic chan_a_pin_oe_n,
    output logic chan_a_override,
    output logic chan_b_compare_pin,
    output logic chan_b_pin_oe_n,
    output logic chan_b_override,
    output logic overflow_flag,
    output logic chan_a_compare_flag,
    output logic chan_b_compare_flag
);

    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] counter_value;
    logic count_down;
    logic [7:0] chan_a_compare_value;
    logic [7:0] chan_b_compare_value;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic wave_a;
    logic wave_b;

    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == wave_pc_ff) || (m == wave_pc_cmp) || (m == wave_fast_ff)
            || (m == wave_fast_cmp);
    endfunction

    function automatic logic is_phase(input logic [2:0] m);
        is_phase = (m == wave_pc_ff) || (m == wave_pc_cmp);
    endfunction

    // next pin level for one channel; covers every mode table
    function automatic logic wave_next(
        input logic cur,
        input logic [2:0] m,
        input logic [1:0] om,
        input logic match,
        input logic at_top_wrap,
        input logic down,
        input logic chan_is_a,
        input logic cmp_is_top
    );
        logic hit;
        hit = match;
        wave_next = cur;
        if (is_pwm(m) && om[1] && cmp_is_top)
        begin
            hit = 1'b0;
        end
        if (!is_pwm(m))
        begin
            if (hit)
            begin
                unique case (om)
                    om_off: wave_next = cur;
                    om_toggle: wave_next = ~cur;
                    om_clear: wave_next = 1'b0;
                    om_set: wave_next = 1'b1;
                endcase
            end
        end
        else if (om == om_toggle)
        begin
            if (hit && chan_is_a && m[2])
            begin
                wave_next = ~cur;
            end
        end
        else if (om[1])
        begin
            if (is_phase(m))
            begin
                if (hit)
                begin
                    wave_next = down ? ~om[0] : om[0];
                end
                else if (cmp_is_top && at_top_wrap)
                begin
                    wave_next = ~om[0];
                end
            end
            else
            begin
                if (hit)
                begin
                    wave_next = om[0];
                end
                else if (at_top_wrap)
                begin
                    wave_next = ~om[0];
                end
            end
        end
    endfunction

    wire [2:0] waveform_mode = {ctrl_b[pos_wgm2], ctrl_a[pos_wgm_hi:pos_wgm_lo]};
    wire mode_pwm = is_pwm(waveform_mode);
    wire mode_phase = is_phase(waveform_mode);
    wire top_from_cmp = (waveform_mode == wave_clear_match) || waveform_mode[2];
    wire [7:0] top_value = top_from_cmp ? chan_a_compare_value : val_max;
    wire [1:0] chan_a_output_mode = ctrl_a[pos_mode_a_hi:pos_mode_a_lo];
    wire [1:0] chan_b_output_mode = ctrl_a[pos_mode_b_hi:pos_mode_b_lo];

    wire at_top = (counter_value == top_value);
    wire at_bottom = (counter_value == val_bottom);
    // phase modes need the top event too, for a compare value sitting at top
    wire wrap_top = timer_tick && at_top;
    wire match_a = timer_tick && (counter_value == chan_a_compare_value);
    wire match_b = timer_tick && (counter_value == chan_b_compare_value);

    wire [7:0] next_counter =
        (mode_phase && at_top) ? counter_value - 8'h01 :
        (mode_phase && count_down) ? (at_bottom ? 8'h01 : counter_value - 8'h01) :
        (at_top || at_bottom && 1'b0) ? val_bottom :
        (waveform_mode == wave_normal) ? counter_value + 8'h01 :
        counter_value + 8'h01;
    wire next_down = mode_phase && (at_top ? 1'b1 : (at_bottom ? 1'b0 : count_down));

    wire ovf_event = timer_tick && (
        (mode_phase && at_bottom) ||
        ((waveform_mode == wave_fast_cmp) && at_top) ||
        (!mode_phase && (waveform_mode != wave_fast_cmp) && counter_value == val_max));
    // reload happens as the counter leaves top, so the new value governs the next period
    wire reload_now = mode_pwm && timer_tick && at_top;

    wire wr_ctrl_a = reg_write && (reg_addr == off_ctrl_a);
    wire wr_ctrl_b = reg_write && (reg_addr == off_ctrl_b);
    wire wr_counter = reg_write && (reg_addr == off_counter);
    wire wr_cmp_a = reg_write && (reg_addr == off_cmp_a);
    wire wr_cmp_b = reg_write && (reg_addr == off_cmp_b);
    wire wr_flags = reg_write && (reg_addr == off_flags);

    wire [7:0] flags_view = {5'h00, chan_b_compare_flag, chan_a_compare_flag, overflow_flag};
    wire [7:0] read_mux =
        (reg_addr == off_ctrl_a) ? (ctrl_a & ctrl_a_write_mask) :
        (reg_addr == off_ctrl_b) ? (ctrl_b & ctrl_b_write_mask) :
        (reg_addr == off_counter) ? counter_value :
        (reg_addr == off_cmp_a) ? cmp_a_buf :
        (reg_addr == off_cmp_b) ? cmp_b_buf :
        (reg_addr == off_flags) ? flags_view : 8'h00;

    wire next_wave_a = wave_next(wave_a, waveform_mode, chan_a_output_mode, match_a,
        wrap_top, count_down, 1'b1, chan_a_compare_value == top_value);
    wire next_wave_b = wave_next(wave_b, waveform_mode, chan_b_output_mode, match_b,
        wrap_top, count_down, 1'b0, chan_b_compare_value == top_value);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_a <= ctrl_a_reset;
            ctrl_b <= ctrl_b_reset;
        end
        else
        begin
            if (wr_ctrl_a)
                ctrl_a <= reg_wdata & ctrl_a_write_mask;
            if (wr_ctrl_b)
                ctrl_b <= reg_wdata & ctrl_b_write_mask;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            counter_value <= counter_reset;
            count_down <= 1'b0;
        end
        else if (wr_counter)
        begin
            counter_value <= reg_wdata;
            count_down <= 1'b0;
        end
        else if (timer_tick)
        begin
            counter_value <= next_counter;
            count_down <= next_down;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cmp_a_buf <= 8'h00;
            cmp_b_buf <= 8'h00;
            chan_a_compare_value <= 8'h00;
            chan_b_compare_value <= 8'h00;
        end
        else
        begin
            if (wr_cmp_a)
                cmp_a_buf <= reg_wdata;
            if (wr_cmp_b)
                cmp_b_buf <= reg_wdata;
            if (!mode_pwm || reload_now)
            begin
                chan_a_compare_value <= wr_cmp_a ? reg_wdata : cmp_a_buf;
                chan_b_compare_value <= wr_cmp_b ? reg_wdata : cmp_b_buf;
            end
        end
    end

    // hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            overflow_flag <= 1'b0;
            chan_a_compare_flag <= 1'b0;
            chan_b_compare_flag <= 1'b0;
        end
        else
        begin
            overflow_flag <= ovf_event | (overflow_flag & ~(wr_flags & reg_wdata[pos_flag_ovf]));
            chan_a_compare_flag <= match_a |
                (chan_a_compare_flag & ~(wr_flags & reg_wdata[pos_flag_cmp_a]));
            chan_b_compare_flag <= match_b |
                (chan_b_compare_flag & ~(wr_flags & reg_wdata[pos_flag_cmp_b]));
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wave_a <= 1'b0;
            wave_b <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            wave_a <= next_wave_a;
            wave_b <= next_wave_b;
            reg_rdata <= reg_read ? read_mux : 8'h00;
        end
    end

    // channel b 01 in pwm is reserved and kept disconnected
    wire b_reserved = mode_pwm && (chan_b_output_mode == om_toggle);
    wire a_parked = mode_pwm && (chan_a_output_mode == om_toggle) && !waveform_mode[2];
    assign chan_a_override = (chan_a_output_mode != om_off) && !a_parked;
    assign chan_b_override = (chan_b_output_mode != om_off) && !b_reserved;
    assign chan_a_compare_pin = wave_a;
    assign chan_b_compare_pin = wave_b;
    assign chan_a_pin_oe_n = ~(chan_a_override && chan_a_pin_dir);
    assign chan_b_pin_oe_n = ~(chan_b_override && chan_b_pin_dir);

    chk_ctrl_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_a[3:2] == 2'b00) else $error("control reserved bits nonzero");
    chk_pin_drive_dir: assert property (@(posedge clk_sys) disable iff (rst)
        !chan_a_pin_dir |-> chan_a_pin_oe_n) else $error("pin driven as input");
    chk_pin_b_dir: assert property (@(posedge clk_sys) disable iff (rst)
        !chan_b_pin_dir |-> chan_b_pin_oe_n) else $error("pin b driven as input");
    chk_ctrl_b_mask: assert property (@(posedge clk_sys) disable iff (rst)
        (ctrl_b & ~ctrl_b_write_mask) == 8'h00) else $error("control b spare bits set");
    chk_rdata_reserved: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && reg_addr == off_ctrl_a) |=> reg_rdata[3:2] == 2'b00)
        else $error("reserved bits read nonzero");

    chk_override_mode: assert property (@(posedge clk_sys) disable iff (rst)
        (chan_b_output_mode == om_off) |-> !chan_b_override)
        else $error("override while off");
    chk_override_a_on: assert property (@(posedge clk_sys) disable iff (rst)
        (!mode_pwm && chan_a_output_mode != om_off) |-> chan_a_override)
        else $error("channel a override missing");
    chk_b_reserved_off: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_pwm && chan_b_output_mode == om_toggle) |-> !chan_b_override)
        else $error("reserved channel b mode drives pin");
    chk_a_toggle_parked: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_pwm && chan_a_output_mode == om_toggle && !waveform_mode[2])
        |-> !chan_a_override)
        else $error("channel a toggle without bit2");

    chk_tick_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (!timer_tick && !wr_counter) |=> $stable(counter_value))
        else $error("counter moved without tick");
    chk_wave_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !timer_tick |=> ($stable(wave_a) && $stable(wave_b)))
        else $error("pin moved without tick");
    sequence s_ctc_top;
        timer_tick && waveform_mode == wave_clear_match && at_top && !wr_counter
            && !wr_ctrl_a && !wr_ctrl_b;
    endsequence
    chk_ctc_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        s_ctc_top |=> counter_value == val_bottom && chan_a_compare_flag)
        else $error("clear on match wrap wrong");
    chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
        match_a |=> chan_a_compare_flag) else $error("compare flag a not set on match");

    chk_ovf_normal: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && waveform_mode == wave_normal && counter_value == val_max)
        |=> overflow_flag) else $error("overflow not set at max");
    chk_ovf_fast_top: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && waveform_mode == wave_fast_cmp && at_top) |=> overflow_flag)
        else $error("overflow not set at top");
    chk_ovf_phase_bottom: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && mode_phase && at_bottom) |=> overflow_flag)
        else $error("overflow not set at bottom");
    chk_phase_turn: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && mode_phase && at_top && !wr_counter) |=> count_down)
        else $error("phase count did not turn at top");
    chk_top_from_cmp: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && waveform_mode == wave_fast_cmp && !wr_counter
        && counter_value == chan_a_compare_value) |=> counter_value == val_bottom)
        else $error("fast count did not wrap at compare top");

    chk_cmp_immediate: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_cmp_a && !mode_pwm && !wr_ctrl_a && !wr_ctrl_b) |=>
        chan_a_compare_value == $past(reg_wdata)) else $error("compare not immediate");
    chk_pwm_cmp_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_pwm && !reload_now) |=> $stable(chan_a_compare_value))
        else $error("buffered compare moved before top");

    sequence s_fast_match_a;
        match_a && waveform_mode == wave_fast_ff && chan_a_output_mode == om_clear
            && chan_a_compare_value != top_value;
    endsequence
    chk_fast_clear_match: assert property (@(posedge clk_sys) disable iff (rst)
        s_fast_match_a |=> !wave_a) else $error("fast match did not clear");
    chk_fast_set_top: assert property (@(posedge clk_sys) disable iff (rst)
        (waveform_mode == wave_fast_ff && chan_a_output_mode == om_clear && wrap_top
        && !match_a && !wr_ctrl_a && !wr_ctrl_b) |=> wave_a) else $error("top set missed");
    sequence s_phase_up_b;
        match_b && mode_phase && !count_down && chan_b_output_mode == om_clear
            && chan_b_compare_value != top_value;
    endsequence
    chk_phase_up_clear: assert property (@(posedge clk_sys) disable iff (rst)
        s_phase_up_b |=> !wave_b) else $error("up match did not clear");
    sequence s_phase_down_b;
        match_b && mode_phase && count_down && chan_b_output_mode == om_clear
            && chan_b_compare_value != top_value;
    endsequence
    chk_phase_down_set: assert property (@(posedge clk_sys) disable iff (rst)
        s_phase_down_b |=> wave_b) else $error("down match did not set");

    chk_top_equal_a: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && mode_pwm && at_top && chan_a_output_mode == om_set
        && chan_a_compare_value == top_value) |=> !wave_a)
        else $error("channel a top action missed");
    chk_top_equal_b: assert property (@(posedge clk_sys) disable iff (rst)
        (timer_tick && mode_pwm && at_top && chan_b_output_mode == om_clear
        && chan_b_compare_value == top_value) |=> wave_b)
        else $error("channel b top action missed");

endmodule

`default_nettype wire

// ==== shared/timer8_pkg.sv ====
package timer8_pkg;

    localparam logic [7:0] val_max = 8'hFF;
    localparam logic [7:0] val_bottom = 8'h00;
    localparam logic [7:0] ctrl_a_reset = 8'h00;
    localparam logic [7:0] ctrl_b_reset = 8'h00;
    localparam logic [7:0] counter_reset = 8'h00;

    // register offsets on the plain port
    localparam logic [2:0] off_ctrl_a = 3'h0;
    localparam logic [2:0] off_ctrl_b = 3'h1;
    localparam logic [2:0] off_counter = 3'h2;
    localparam logic [2:0] off_cmp_a = 3'h3;
    localparam logic [2:0] off_cmp_b = 3'h4;
    localparam logic [2:0] off_flags = 3'h5;

    // field positions in control register a
    localparam int pos_mode_a_hi = 7;
    localparam int pos_mode_a_lo = 6;
    localparam int pos_mode_b_hi = 5;
    localparam int pos_mode_b_lo = 4;
    localparam int pos_wgm_hi = 1;
    localparam int pos_wgm_lo = 0;
    localparam logic [7:0] ctrl_a_write_mask = 8'hF3;
    // field position in control register b
    localparam int pos_wgm2 = 3;
    localparam logic [7:0] ctrl_b_write_mask = 8'h08;

    // flag register bit positions, write one to clear
    localparam int pos_flag_ovf = 0;
    localparam int pos_flag_cmp_a = 1;
    localparam int pos_flag_cmp_b = 2;

    typedef enum logic [2:0] {
        wave_normal = 3'b000,
        wave_pc_ff = 3'b001,
        wave_clear_match = 3'b010,
        wave_fast_ff = 3'b011,
        wave_resv4 = 3'b100,
        wave_pc_cmp = 3'b101,
        wave_resv6 = 3'b110,
        wave_fast_cmp = 3'b111
    } waveform_mode_t;

    typedef enum logic [1:0] {
        om_off = 2'b00,
        om_toggle = 2'b01,
        om_clear = 2'b10,
        om_set = 2'b11
    } output_mode_t;

endpackage

// ==== testbench/timer8_waveform_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module timer8_waveform_control_tb;
    import timer8_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic timer_tick = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic dir_a = 1'b0;
    logic dir_b = 1'b0;
    logic pin_a, oe_a_n, ovr_a, pin_b, oe_b_n, ovr_b, ovf, flag_a, flag_b;
    logic [7:0] v;
    logic [7:0] r;
    logic pa;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;

    timer8_waveform_control uut (
        .clk_sys(clk_sys), .rst(rst), .timer_tick(timer_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .chan_a_pin_dir(dir_a), .chan_b_pin_dir(dir_b),
        .chan_a_compare_pin(pin_a), .chan_a_pin_oe_n(oe_a_n), .chan_a_override(ovr_a),
        .chan_b_compare_pin(pin_b), .chan_b_pin_oe_n(oe_b_n), .chan_b_override(ovr_b),
        .overflow_flag(ovf), .chan_a_compare_flag(flag_a), .chan_b_compare_flag(flag_b)
    );

    always #12.5 clk_sys = ~clk_sys;

    task automatic end_sim();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // generous ceiling, the sequence needs about 1000 cycles
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    // data is only valid in the single cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic ticks(input int k);
        repeat (k)
        begin
            @(posedge clk_sys);
            timer_tick <= 1'b1;
            @(posedge clk_sys);
            timer_tick <= 1'b0;
        end
        #1;
    endtask

    function automatic logic exp_ovr(input logic [2:0] m, input logic [1:0] om, input logic is_a);
        logic pwm;
        pwm = m[0];
        if (om == om_off)
            return 1'b0;
        if (pwm && om == om_toggle)
            return is_a && m[2];
        return 1'b1;
    endfunction

    initial
    begin
        void'($urandom(3457));
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({6'h00, ovr_a, ovr_b}, 8'h00);
        chk({6'h00, oe_a_n, oe_b_n}, 8'h03);
        for (int i = 0; i < 6; i++)
        begin
            rd(3'(i), v);
            chk(v, 8'h00);
        end
        @(posedge clk_sys);
        #1;
        chk(reg_rdata, 8'h00);
        $display("test reset done");

        for (int m = 0; m < 8; m++)
        begin
            for (int om = 0; om < 4; om++)
            begin
                dir_a <= 1'($urandom);
                dir_b <= 1'($urandom);
                wr(off_ctrl_b, {4'h0, 1'(m >> 2), 3'h0});
                wr(off_ctrl_a, {2'(om), 2'(om), 2'b00, 2'(m)});
                #1;
                chk(ovr_a, exp_ovr(3'(m), 2'(om), 1'b1));
                chk(ovr_b, exp_ovr(3'(m), 2'(om), 1'b0));
                chk(oe_a_n, !(exp_ovr(3'(m), 2'(om), 1'b1) && dir_a));
                chk(oe_b_n, !(exp_ovr(3'(m), 2'(om), 1'b0) && dir_b));
            end
        end
        $display("test override done");

        repeat (8)
        begin
            v = 8'($urandom);
            wr(off_ctrl_a, v);
            rd(off_ctrl_a, r);
            chk(r, v & ctrl_a_write_mask);
            wr(off_ctrl_b, ~v);
            rd(off_ctrl_b, r);
            chk(r, ~v & ctrl_b_write_mask);
            wr(3'h6 + 3'(v[0]), v);
            rd(3'h6 + 3'(v[0]), r);
            chk(r, 8'h00);
        end
        wr(off_ctrl_a, 8'h00);
        wr(off_ctrl_b, 8'h00);
        $display("test registers done");

        wr(off_counter, 8'h00);
        n = 0;
        repeat (60)
        begin
            @(posedge clk_sys);
            pa = 1'($urandom);
            timer_tick <= pa;
            n += int'(pa);
        end
        @(posedge clk_sys);
        timer_tick <= 1'b0;
        rd(off_counter, v);
        chk(v, 8'(n));
        $display("test tick done");

        wr(off_cmp_a, 8'h12);
        wr(off_cmp_b, 8'h12);
        wr(off_counter, 8'h10);
        wr(off_flags, 8'hFF);
        wr(off_ctrl_a, 8'h70);
        #1;
        pa = pin_a;
        ticks(4);
        chk({pin_a, pin_b}, {~pa, 1'b1});
        wr(off_counter, 8'h10);
        wr(off_ctrl_a, 8'hA0);
        ticks(4);
        chk({pin_a, pin_b}, 2'b00);
        rd(off_flags, v);
        chk(v, 8'h06);
        chk({5'h00, flag_b, flag_a, ovf}, 8'h06);
        $display("test normal compare done");

        wr(off_flags, 8'hFF);
        wr(off_counter, 8'hFE);
        ticks(2);
        rd(off_counter, v);
        chk(v, val_bottom);
        rd(off_flags, v);
        chk(v, 8'h01);
        wr(off_flags, 8'h01);
        rd(off_flags, v);
        chk(v, 8'h00);
        $display("test overflow done");

        wr(off_ctrl_a, 8'h02);
        wr(off_flags, 8'hFF);
        wr(off_cmp_a, 8'h05);
        wr(off_counter, 8'h03);
        ticks(3);
        rd(off_counter, v);
        chk(v, 8'h00);
        rd(off_flags, v);
        chk(v, 8'h02);
        ticks(1);
        rd(off_counter, v);
        chk(v, 8'h01);
        $display("test clear on match done");

        wr(off_cmp_a, 8'h12);
        wr(off_counter, 8'h10);
        wr(off_ctrl_a, 8'hB3);
        ticks(4);
        chk({pin_a, pin_b}, 2'b01);
        wr(off_flags, 8'hFF);
        wr(off_counter, 8'hFE);
        ticks(3);
        chk({pin_a, pin_b}, 2'b10);
        rd(off_flags, v);
        chk(v, 8'h01);
        // buffered value must not act before the next top
        wr(off_cmp_a, 8'h08);
        ticks(10);
        chk(pin_a, 1'b1);
        // compare values at top: the match is ignored, the top action still happens
        wr(off_cmp_a, 8'hFF);
        wr(off_cmp_b, 8'hFF);
        wr(off_counter, 8'hFF);
        ticks(1);
        wr(off_counter, 8'hFF);
        ticks(1);
        chk({pin_a, pin_b}, 2'b10);
        $display("test fast pwm done");

        wr(off_ctrl_a, 8'h00);
        wr(off_cmp_a, 8'h04);
        wr(off_cmp_b, 8'h04);
        wr(off_counter, 8'h02);
        wr(off_ctrl_a, 8'hB1);
        ticks(4);
        chk({pin_a, pin_b}, 2'b01);
        wr(off_counter, 8'hFE);
        wr(off_flags, 8'hFF);
        ticks(253);
        chk({pin_a, pin_b}, 2'b10);
        rd(off_flags, v);
        chk(v, 8'h06);
        ticks(5);
        rd(off_flags, v);
        chk(v & 8'h01, 8'h01);
        $display("test phase correct done");

        wr(off_flags, 8'hFF);
        wr(off_ctrl_b, 8'h08);
        wr(off_ctrl_a, 8'h03);
        wr(off_counter, 8'h02);
        ticks(3);
        rd(off_counter, v);
        chk(v, val_bottom);
        rd(off_flags, v);
        chk(v, 8'h07);
        $display("test compare top done");
        end_sim();
    end
endmodule

`default_nettype wire
